// ---- bench/cds_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// physical memory and remap service beside the unit
module cds_mem_model #(
  parameter logic [14:0] ENTRY = 15'h2800
) (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [14:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] slow_i,
  input wire logic remap_i,
  output logic ack_o,
  output logic [15:0] rdata_o,
  output logic remap_ack_o,
  output logic [14:0] entry_o
);
  logic [15:0] mem [0:32767];
  logic [1:0] wait_q;
  initial begin
    ack_o = 1'b0;
    rdata_o = 16'h0000;
    wait_q = 2'h0;
    remap_ack_o = 1'b0;
    // known contents, so every read compare means something
    for (int i = 0; i < 32768; i++) mem[i] = 16'(i * 3);
  end
  // one word per request, after slow_i idle cycles
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o; // never leave a stale word on the bus
    if (req_i && !ack_o) begin
      if (wait_q >= slow_i) begin
        ack_o <= 1'b1;
        wait_q <= 2'h0;
        if (we_i) mem[addr_i] <= wdata_i;
        else rdata_o <= mem[addr_i];
      end else wait_q <= wait_q + 2'h1;
    end
  end
  // remap request answered one cycle after it shows
  always @(posedge clk_i) remap_ack_o <= remap_i && !remap_ack_o;
  assign entry_o = ENTRY;
endmodule : cds_mem_model
`default_nettype wire

// ---- bench/cds_unit_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module cds_unit_tb;
  logic clk_i, arst_n_i, split_on_i, split_off_i, acc_valid_i, acc_first_i, acc_we_i;
  logic cross_i, mem_ack_i, remap_ack_i, call_start_i, move_start_i, split_en_o, acc_ready_o;
  logic acc_done_o, mem_req_o, mem_we_o, mem_code_o, mem_acc_o, call_busy_o, call_done_o;
  logic call_overflow_o, remap_valid_o, move_busy_o, move_done_o, sp, cd;
  logic [4:0] exec_map_i, cross_map_i, mem_map_o, trap_map_o;
  logic [14:0] base_q_i, bounds_i, pc_i, acc_addr_i, remap_entry_i, mem_addr_o, new_pc_o;
  logic [14:0] new_q_o, trap_addr_o;
  logic [15:0] acc_wdata_i, mem_rdata_i, move_count_i, acc_rdata_o, mem_wdata_o, remap_o;
  logic [21:0] exp;
  cds_pkg::acc_kind_t acc_kind_i;
  cds_pkg::call_kind_t call_kind_i;
  logic [1:0] slow;
  logic [31:0] rnd;
  int mismatches, n_compared, cyc;

  cds_unit dut_u (.clk_i, .arst_n_i, .split_on_i, .split_off_i, .exec_map_i, .base_q_i,
    .bounds_i, .pc_i, .acc_valid_i, .acc_kind_i, .acc_first_i, .acc_we_i, .acc_addr_i,
    .acc_wdata_i, .cross_i, .cross_map_i, .mem_ack_i, .mem_rdata_i, .call_start_i,
    .call_kind_i, .remap_ack_i, .remap_entry_i, .move_start_i, .move_count_i, .split_en_o,
    .acc_ready_o, .acc_done_o, .acc_rdata_o, .mem_req_o, .mem_we_o, .mem_code_o, .mem_acc_o,
    .mem_map_o, .mem_addr_o, .mem_wdata_o, .call_busy_o, .call_done_o, .call_overflow_o,
    .new_pc_o, .new_q_o, .trap_map_o, .trap_addr_o, .remap_valid_o, .remap_o, .move_busy_o,
    .move_done_o);
  cds_mem_model mem_u (.clk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .slow_i(slow), .remap_i(remap_valid_o), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i), .remap_ack_o(remap_ack_i), .entry_o(remap_entry_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // expected {map, accumulator, code space, address} of one access
  function automatic logic [21:0] xl(input logic s, c, k, input logic [4:0] m, cm,
      input logic [14:0] a, b);
    logic rel;
    rel = s && !c && a >= 15'h0002 && a <= 15'h03ff;
    return {c ? cm : (s && k ? m | 5'h01 : m),
      !k && !c && a <= 15'h0001, k, rel ? a + b : a};
  endfunction : xl

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  // split is switched off before the calls, so neither the base nor the paired code map touches them
  task automatic call(input int k, input logic [14:0] bnd);
    logic [14:0] entry, opc;
    logic [15:0] argc, p;
    argc = 16'(k);
    entry = (k == 1 || k == 2) ? 15'h2800 : 15'h1800;
    opc = new_pc_o;
    mem_u.mem[15'h0804] = 16'h1000;
    // the later kinds reach their label through one indirect level
    mem_u.mem[15'h07d1] = (k >= 2) ? 16'h8830 : 16'h1800;
    mem_u.mem[15'h0830] = 16'h1800;
    mem_u.mem[15'h07d2] = argc;
    mem_u.mem[15'h1800] = (k == 2) ? 16'h1234 : 16'h0014;
    mem_u.mem[15'h2800] = 16'h0014;
    mem_u.mem[15'h0258] = 16'h0190;
    for (int i = 0; i < k; i++) mem_u.mem[15'h07d3 + 15'(i)] = (i == 1) ? 16'h8258 :
      16'h0064 + 16'h012c * 16'(i);
    bounds_i = bnd;
    call_kind_i = cds_pkg::call_kind_t'(k);
    call_start_i = 1'b1;
    @(negedge clk_i);
    call_start_i = 1'b0;
    chk(call_busy_o, 1'b1);
    while (!call_done_o) begin
      if (remap_valid_o) chk(remap_o, (k == 2) ? 16'h1234 : 16'h1800);
      @(negedge clk_i);
    end
    chk(call_busy_o, 1'b0);
    chk(call_overflow_o, bnd <= 15'h1014);
    chk(new_q_o, 15'h1000);
    chk(new_pc_o, (bnd <= 15'h1014) ? opc : entry + 15'h0001);
    chk(mem_u.mem[15'h1000], {k == 1 || k == 2, 15'h07d3 + argc[14:0]});
    chk(mem_u.mem[15'h1001], 16'h0800);
    chk(mem_u.mem[15'h1003], {8'h00, argc[7:0]});
    chk(mem_u.mem[15'h1004], 16'h1014);
    for (int i = 0; i < k; i++) begin
      p = 16'h0064 + 16'h012c * 16'(i);
      chk(mem_u.mem[15'h1006 + 15'(i)], (p <= 16'h03ff) ? p + 16'h0800 : p);
    end
  endtask : call

  task automatic move(input logic [15:0] n);
    int c;
    c = 0;
    move_count_i = n;
    move_start_i = 1'b1;
    @(negedge clk_i);
    move_start_i = 1'b0;
    while (move_busy_o) begin
      c++;
      @(negedge clk_i);
    end
    chk(move_done_o, 1'b1);
    chk(c, (2043 + 9) / 10 + int'(n) * ((4086 + 9) / 10));
  endtask : move

  // cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial begin
    {arst_n_i, split_on_i, split_off_i, acc_valid_i, acc_first_i, acc_we_i, cross_i} = '0;
    {call_start_i, move_start_i, exec_map_i, cross_map_i, acc_addr_i, acc_wdata_i} = '0;
    {move_count_i, slow, mismatches, n_compared, cyc} = '0;
    acc_kind_i = cds_pkg::K_OPCODE;
    call_kind_i = cds_pkg::C_SAME;
    base_q_i = 15'h0800;
    bounds_i = 15'h7000;
    pc_i = 15'h07d0;
    rnd = 32'h37e70ab5;
    repeat (6) @(negedge clk_i);
    chk({trap_map_o, trap_addr_o, split_en_o, mem_req_o, call_busy_o}, 23'h000038);
    arst_n_i = 1'b1;
    repeat (300) begin
      rnd = lfsr(lfsr(rnd));
      sp = rnd[31];
      split_on_i = sp;
      split_off_i = !sp;
      @(negedge clk_i);
      {split_on_i, split_off_i} = 2'b00;
      chk(split_en_o, sp);
      exec_map_i = {rnd[4:1], 1'b0};
      base_q_i = rnd[14:0] | 15'h0400;
      acc_kind_i = cds_pkg::acc_kind_t'(rnd[18:16]);
      acc_first_i = rnd[19];
      cross_i = rnd[20] & rnd[21];
      cross_map_i = rnd[26:22];
      acc_addr_i = rnd[28] ? rnd[14:0] : 15'(rnd[30:29]) + (rnd[27] ? 15'h03fe : 15'h0);
      cd = acc_kind_i <= cds_pkg::K_MEMREF_CONST ||
        (acc_kind_i == cds_pkg::K_MEMREF_CP && acc_first_i);
      acc_we_i = !cd && rnd[15];
      acc_wdata_i = rnd[31:16];
      slow = rnd[25:24];
      exp = xl(sp, cross_i, cd, exec_map_i, cross_map_i, acc_addr_i, base_q_i);
      while (!acc_ready_o) @(negedge clk_i);
      acc_valid_i = 1'b1;
      @(negedge clk_i);
      acc_valid_i = 1'b0;
      chk({mem_req_o, mem_we_o, mem_map_o, mem_acc_o, mem_code_o, mem_addr_o},
        {1'b1, acc_we_i, exp});
      if (acc_we_i) chk(mem_wdata_o, acc_wdata_i);
      while (!acc_done_o) @(negedge clk_i);
      if (!acc_we_i) chk(acc_rdata_o, mem_u.mem[exp[14:0]]);
    end
    split_off_i = 1'b1;
    base_q_i = 15'h0800;
    @(negedge clk_i);
    split_off_i = 1'b0;
    for (int k = 0; k < 5; k++) call(k, 15'h7000);
    call(0, 15'h1014);
    move(16'h0000);
    move(16'h0001);
    tally_and_finish();
  end
endmodule : cds_unit_tb
`default_nettype wire

// ---- src/cds_pkg.sv ----
package cds_pkg;

  // address and map geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int MAP_W = 5;
  localparam int NUM_MAPS = 32;
  localparam int PAGES_PER_MAP = 32;
  localparam int IND_BIT = 15;

  // base window and accumulator locations of data space
  localparam logic [14:0] BASE_LO = 15'h0002;
  localparam logic [14:0] BASE_HI = 15'h03ff;
  localparam logic [14:0] ACC_B_ADDR = 15'h0001;
  localparam logic [4:0] CODE_MAP_BIT = 5'h01;

  // stack overflow trap target
  localparam logic [14:0] TRAP_VEC = 15'h0007;
  localparam logic [4:0] TRAP_MAP = 5'h00;

  // call sequence layout relative to the call opcode
  localparam logic [14:0] LABEL_OFS = 15'h0001;
  localparam logic [14:0] COUNT_OFS = 15'h0002;
  localparam logic [14:0] ARGS_OFS = 15'h0003;
  localparam logic [14:0] ENTRY_TO_PC = 15'h0001;

  // stack marker layout, words from the new base
  localparam logic [14:0] MARKER_WORDS = 15'h0006;
  localparam logic [2:0] MARK_LAST = 3'h5;
  localparam logic [2:0] W_RETURN_P = 3'h0;
  localparam logic [2:0] W_PREV_Q = 3'h1;
  localparam logic [2:0] W_ARGCNT = 3'h3;
  localparam logic [2:0] W_NEXT_Q = 3'h4;
  localparam logic [14:0] NEXT_Q_OFS = 15'h0004;

  // cross byte move timing
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real MOVE_SETUP_US = 2.043;
  localparam real MOVE_BYTE_US = 4.086;
  localparam int MOVE_SETUP_CYC = int'($ceil(MOVE_SETUP_US * 1000.0 / CLK_PERIOD_NS));
  localparam int MOVE_BYTE_CYC = int'($ceil(MOVE_BYTE_US * 1000.0 / CLK_PERIOD_NS));
  localparam logic [8:0] SETUP_LOAD = 9'(MOVE_SETUP_CYC - 1);
  localparam logic [8:0] BYTE_LOAD = 9'(MOVE_BYTE_CYC - 1);

  typedef enum logic [2:0] {
    K_OPCODE = 3'b000,
    K_OPERAND = 3'b001,
    K_INLINE = 3'b010,
    K_CP_LINK = 3'b011,
    K_MEMREF_CONST = 3'b100,
    K_DATA = 3'b101,
    K_MEMREF_BASE = 3'b110,
    K_MEMREF_CP = 3'b111
  } acc_kind_t;

  typedef enum logic [2:0] {
    C_SAME = 3'b000,
    C_CROSS = 3'b001,
    C_CROSS_VAR = 3'b010,
    C_LEGACY_ONE = 3'b011,
    C_LEGACY_TWO = 3'b100
  } call_kind_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_NQ = 4'b0001,
    S_LABEL = 4'b0010,
    S_LIND = 4'b0011,
    S_VREAD = 4'b0100,
    S_REMAP = 4'b0101,
    S_COUNT = 4'b0110,
    S_ARG = 4'b0111,
    S_AIND = 4'b1000,
    S_AWR = 4'b1001,
    S_FRAME = 4'b1010,
    S_MARK = 4'b1011,
    S_DONE = 4'b1100
  } seq_state_t;

endpackage : cds_pkg

// ---- src/cds_unit.sv ----
// How it works
// [RULE1] split off: code and data both go through the execute map
// [RULE2] split on: data uses execute map, code uses it with bit zero set
// [RULE3] software keeps the execute map even, 0 to 30
// [RULE4] split on: addresses 2..1023 get the base added before access
// [RULE5] data addresses 0 and 1 select accumulators, no base added; the code keeps cross-map accesses off the accumulators
// [RULE6] cross-map accesses run as if split were off
// [RULE7] opcodes, operand words, constants and links are code; variables are data
// [RULE8] split programs avoid subroutine jump and current-page direct stores
// [RULE9] base-page memory-reference accesses go to data space
// [RULE10] current-page reference: first access code, later levels data
// [RULE11] software keeps the base between 1024 and 32767
// [RULE12] program counter stays between 1024 and 32767
// [RULE13] each call moves the base to a fresh marker then branches; on overflow the code leaves new_pc_o unchanged
// [RULE14] five call kinds: same, cross fixed, cross variable, two legacy
// [RULE15] sequence: opcode, label, count, pointers, return; entry holds frame size
// [RULE16] label is an address, remap word, or pointer to a remap word
// [RULE17] up to 255 pointers, bit 15 of each flags indirection
// [RULE18] byte move takes setup time plus a fixed time per byte
// [RULE19] next base at or above bounds raises the overflow trap
// [RULE20] a six-word marker is written at the base of each new frame
// [RULE21] one split-enable state steers every memory cycle
`timescale 1ns/10ps
`default_nettype none
module cds_unit (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic split_on_i,
  input wire logic split_off_i,
  input wire logic [4:0] exec_map_i,
  input wire logic [14:0] base_q_i,
  input wire logic [14:0] bounds_i,
  input wire logic [14:0] pc_i,
  input wire logic acc_valid_i,
  input wire cds_pkg::acc_kind_t acc_kind_i,
  input wire logic acc_first_i,
  input wire logic acc_we_i,
  input wire logic [14:0] acc_addr_i,
  input wire logic [15:0] acc_wdata_i,
  input wire logic cross_i,
  input wire logic [4:0] cross_map_i,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  input wire logic call_start_i,
  input wire cds_pkg::call_kind_t call_kind_i,
  input wire logic remap_ack_i,
  input wire logic [14:0] remap_entry_i,
  input wire logic move_start_i,
  input wire logic [15:0] move_count_i,
  output logic split_en_o,
  output logic acc_ready_o,
  output logic acc_done_o,
  output logic [15:0] acc_rdata_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic mem_code_o,
  output logic mem_acc_o,
  output logic [4:0] mem_map_o,
  output logic [14:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic call_busy_o,
  output logic call_done_o,
  output logic call_overflow_o,
  output logic [14:0] new_pc_o,
  output logic [14:0] new_q_o,
  output logic [4:0] trap_map_o,
  output logic [14:0] trap_addr_o,
  output logic remap_valid_o,
  output logic [15:0] remap_o,
  output logic move_busy_o,
  output logic move_done_o
);

  cds_pkg::seq_state_t state_q;
  cds_pkg::call_kind_t kind_q;
  logic [14:0] newq_q;
  logic [15:0] ptr_q;
  logic [14:0] entry_q;
  logic [7:0] argc_q;
  logic [7:0] idx_q;
  logic [15:0] nextq_q;
  logic [2:0] mark_q;
  logic owner_proc_q;
  logic iss_valid, iss_code, iss_we, iss_cross, iss_proc;
  logic [14:0] iss_addr;
  logic [15:0] iss_wdata;
  logic [4:0] iss_map_xl;
  logic [14:0] iss_addr_xl;
  logic iss_acc_xl;
  logic seq_ack;
  logic ptr_in_window;
  logic legacy;
  logic [8:0] mv_cnt_q;
  logic [15:0] mv_bytes_q;

  assign seq_ack = mem_req_o & mem_ack_i & ~owner_proc_q;
  assign legacy = (kind_q == cds_pkg::C_LEGACY_ONE) || (kind_q == cds_pkg::C_LEGACY_TWO);
  assign ptr_in_window = (ptr_q[14:0] >= cds_pkg::BASE_LO) && (ptr_q[14:0] <= cds_pkg::BASE_HI);

  // the split state; a late off in the same cycle as on leaves it on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      split_en_o <= 1'b0;
    end else if (split_on_i) begin
      split_en_o <= 1'b1; // [RULE21]
    end else if (split_off_i) begin
      split_en_o <= 1'b0;
    end
  end

  // pick the next memory access: the call sequencer owns the port while busy
  always_comb begin
    iss_valid = 1'b0;
    iss_code = 1'b0;
    iss_we = 1'b0;
    iss_cross = 1'b0;
    iss_proc = 1'b0;
    iss_addr = '0;
    iss_wdata = '0;
    if (!mem_req_o) begin
      case (state_q)
        cds_pkg::S_IDLE: if (acc_valid_i && !call_start_i) begin
          iss_valid = 1'b1;
          iss_proc = 1'b1;
          iss_we = acc_we_i;
          iss_addr = acc_addr_i;
          iss_wdata = acc_wdata_i;
          iss_cross = cross_i;
          // base page is data; current page is code on the first level only
          iss_code = (acc_kind_i <= cds_pkg::K_MEMREF_CONST) || // [RULE7]
                     ((acc_kind_i == cds_pkg::K_MEMREF_CP) && acc_first_i); // [RULE9] [RULE10]
        end
        cds_pkg::S_NQ: begin
          iss_valid = 1'b1;
          iss_addr = 15'(base_q_i + cds_pkg::NEXT_Q_OFS); // [RULE13]
        end
        cds_pkg::S_LABEL: begin
          iss_valid = 1'b1;
          iss_code = 1'b1;
          iss_addr = 15'(pc_i + cds_pkg::LABEL_OFS); // [RULE15]
        end
        cds_pkg::S_LIND, cds_pkg::S_VREAD, cds_pkg::S_AIND: begin
          iss_valid = 1'b1;
          iss_addr = ptr_q[14:0];
        end
        cds_pkg::S_COUNT: begin
          iss_valid = 1'b1;
          iss_code = 1'b1;
          iss_addr = 15'(pc_i + cds_pkg::COUNT_OFS); // [RULE15]
        end
        cds_pkg::S_ARG: begin
          iss_valid = 1'b1;
          iss_code = 1'b1;
          iss_addr = 15'(pc_i + cds_pkg::ARGS_OFS + {7'h00, idx_q}); // [RULE15]
        end
        cds_pkg::S_AWR: begin
          iss_valid = 1'b1;
          iss_we = 1'b1;
          iss_addr = 15'(newq_q + cds_pkg::MARKER_WORDS + {7'h00, idx_q});
          // a resolved low pointer is made absolute with the caller's base
          iss_wdata = {1'b0, 15'(ptr_q[14:0] + (ptr_in_window ? base_q_i : 15'h0000))};
        end
        cds_pkg::S_FRAME: begin
          iss_valid = 1'b1;
          iss_code = ~legacy; // legacy code lives in data space [RULE14]
          iss_addr = entry_q; // [RULE15]
        end
        cds_pkg::S_MARK: begin
          iss_valid = 1'b1;
          iss_we = 1'b1;
          iss_addr = 15'(newq_q + {12'h000, mark_q}); // [RULE20]
          case (mark_q)
            cds_pkg::W_RETURN_P: iss_wdata = {(kind_q == cds_pkg::C_CROSS) ||
                                              (kind_q == cds_pkg::C_CROSS_VAR),
                                              15'(pc_i + cds_pkg::ARGS_OFS + {7'h00, argc_q})};
            cds_pkg::W_PREV_Q: iss_wdata = {1'b0, base_q_i};
            cds_pkg::W_ARGCNT: iss_wdata = {8'h00, argc_q};
            cds_pkg::W_NEXT_Q: iss_wdata = {1'b0, nextq_q[14:0]};
            default: iss_wdata = '0;
          endcase
        end
        default: iss_valid = 1'b0;
      endcase
    end
  end

  cds_xlate u_xlate (
    .split_en_i(split_en_o),
    .cross_i(iss_cross),
    .code_i(iss_code),
    .exec_map_i(exec_map_i),
    .cross_map_i(cross_map_i),
    .addr_i(iss_addr),
    .base_i(base_q_i),
    .map_o(iss_map_xl),
    .addr_o(iss_addr_xl),
    .acc_o(iss_acc_xl)
  );

  // memory port: one access in flight, held until acknowledged
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_code_o <= 1'b0;
      mem_acc_o <= 1'b0;
      mem_map_o <= '0;
      mem_addr_o <= '0;
      mem_wdata_o <= '0;
      owner_proc_q <= 1'b0;
    end else if (!mem_req_o && iss_valid) begin
      mem_req_o <= 1'b1;
      mem_we_o <= iss_we;
      mem_code_o <= iss_code;
      mem_acc_o <= iss_acc_xl;
      mem_map_o <= iss_map_xl;
      mem_addr_o <= iss_addr_xl;
      mem_wdata_o <= iss_wdata;
      owner_proc_q <= iss_proc;
    end else if (mem_req_o && mem_ack_i) begin
      mem_req_o <= 1'b0;
    end
  end

  // processor side answer and readiness; ready is one cycle pessimistic
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_done_o <= 1'b0;
      acc_rdata_o <= '0;
      acc_ready_o <= 1'b0;
    end else begin
      acc_done_o <= mem_req_o & mem_ack_i & owner_proc_q;
      if (mem_req_o && mem_ack_i && owner_proc_q) begin
        acc_rdata_o <= mem_rdata_i;
      end
      acc_ready_o <= (state_q == cds_pkg::S_IDLE) && !call_start_i && !mem_req_o && !iss_valid;
    end
  end

  // procedure call sequencer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= cds_pkg::S_IDLE;
      kind_q <= cds_pkg::C_SAME;
      newq_q <= '0;
      ptr_q <= '0;
      entry_q <= '0;
      argc_q <= '0;
      idx_q <= '0;
      nextq_q <= '0;
      mark_q <= '0;
      call_busy_o <= 1'b0;
      call_done_o <= 1'b0;
      call_overflow_o <= 1'b0;
      new_pc_o <= '0;
      new_q_o <= '0;
      remap_valid_o <= 1'b0;
      remap_o <= '0;
    end else begin
      call_done_o <= 1'b0;
      call_overflow_o <= 1'b0;
      case (state_q)
        cds_pkg::S_IDLE: if (call_start_i && !mem_req_o) begin
          kind_q <= call_kind_i; // [RULE14]
          call_busy_o <= 1'b1;
          state_q <= cds_pkg::S_NQ;
        end
        cds_pkg::S_NQ: if (seq_ack) begin
          newq_q <= mem_rdata_i[14:0]; // new frame starts at the old next base [RULE13]
          state_q <= cds_pkg::S_LABEL;
        end
        cds_pkg::S_LABEL, cds_pkg::S_LIND: if (seq_ack) begin
          ptr_q <= mem_rdata_i;
          if (kind_q == cds_pkg::C_CROSS && state_q == cds_pkg::S_LABEL) begin
            remap_o <= mem_rdata_i; // label word is the remap itself [RULE16]
            remap_valid_o <= 1'b1;
            state_q <= cds_pkg::S_REMAP;
          end else if (mem_rdata_i[cds_pkg::IND_BIT]) begin
            state_q <= cds_pkg::S_LIND; // [RULE16]
          end else if (kind_q == cds_pkg::C_CROSS_VAR) begin
            state_q <= cds_pkg::S_VREAD; // [RULE16]
          end else begin
            entry_q <= mem_rdata_i[14:0];
            state_q <= cds_pkg::S_COUNT;
          end
        end
        cds_pkg::S_VREAD: if (seq_ack) begin
          remap_o <= mem_rdata_i;
          remap_valid_o <= 1'b1;
          state_q <= cds_pkg::S_REMAP;
        end
        cds_pkg::S_REMAP: if (remap_ack_i) begin
          remap_valid_o <= 1'b0;
          entry_q <= remap_entry_i;
          state_q <= cds_pkg::S_COUNT;
        end
        cds_pkg::S_COUNT: if (seq_ack) begin
          argc_q <= mem_rdata_i[7:0]; // [RULE17]
          idx_q <= '0;
          state_q <= (mem_rdata_i[7:0] == 8'h00) ? cds_pkg::S_FRAME : cds_pkg::S_ARG;
        end
        cds_pkg::S_ARG, cds_pkg::S_AIND: if (seq_ack) begin
          ptr_q <= mem_rdata_i;
          // follow indirection until a direct pointer turns up
          state_q <= mem_rdata_i[cds_pkg::IND_BIT] ? cds_pkg::S_AIND : cds_pkg::S_AWR; // [RULE17]
        end
        cds_pkg::S_AWR: if (seq_ack) begin
          idx_q <= 8'(idx_q + 8'h01);
          state_q <= (8'(idx_q + 8'h01) == argc_q) ? cds_pkg::S_FRAME : cds_pkg::S_ARG;
        end
        cds_pkg::S_FRAME: if (seq_ack) begin
          nextq_q <= 16'({1'b0, newq_q} + {1'b0, mem_rdata_i[14:0]});
          mark_q <= '0;
          state_q <= cds_pkg::S_MARK;
        end
        cds_pkg::S_MARK: if (seq_ack) begin
          mark_q <= 3'(mark_q + 3'h1);
          if (mark_q == cds_pkg::MARK_LAST) begin
            state_q <= cds_pkg::S_DONE; // [RULE20]
          end
        end
        cds_pkg::S_DONE: begin
          call_done_o <= 1'b1;
          call_busy_o <= 1'b0;
          new_q_o <= newq_q;
          // marker may already sit above bounds; that is why the trap exists
          if (nextq_q >= {1'b0, bounds_i}) begin
            call_overflow_o <= 1'b1; // [RULE19]
          end else begin
            new_pc_o <= 15'(entry_q + cds_pkg::ENTRY_TO_PC); // [RULE13]
          end
          state_q <= cds_pkg::S_IDLE;
        end
        default: state_q <= cds_pkg::S_IDLE;
      endcase
    end
  end

  // trap target is fixed
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      trap_map_o <= cds_pkg::TRAP_MAP;
      trap_addr_o <= cds_pkg::TRAP_VEC; // [RULE19]
    end else begin
      trap_map_o <= cds_pkg::TRAP_MAP;
      trap_addr_o <= cds_pkg::TRAP_VEC;
    end
  end

  // byte move timer: setup phase, then one slot per byte; a start while busy is ignored
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      move_busy_o <= 1'b0;
      move_done_o <= 1'b0;
      mv_cnt_q <= '0;
      mv_bytes_q <= '0;
    end else begin
      move_done_o <= 1'b0;
      if (!move_busy_o) begin
        if (move_start_i) begin
          move_busy_o <= 1'b1;
          mv_cnt_q <= cds_pkg::SETUP_LOAD; // [RULE18]
          mv_bytes_q <= move_count_i;
        end
      end else if (mv_cnt_q != 9'h000) begin
        mv_cnt_q <= 9'(mv_cnt_q - 9'h001);
      end else if (mv_bytes_q == 16'h0000) begin
        move_busy_o <= 1'b0;
        move_done_o <= 1'b1;
      end else begin
        mv_bytes_q <= 16'(mv_bytes_q - 16'h0001);
        mv_cnt_q <= cds_pkg::BYTE_LOAD; // [RULE18]
      end
    end
  end

  localparam int SETUP_GAP = cds_pkg::MOVE_SETUP_CYC - 7;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_unified_map: assert property ($rose(mem_req_o) && !$past(split_en_o) && !$past(iss_cross) // [RULE1]
    |-> mem_map_o == $past(exec_map_i)) else $error("unified access used wrong map");
  a_code_map_pair: assert property ($rose(mem_req_o) && $past(split_en_o && iss_code && !iss_cross) // [RULE2]
    |-> mem_map_o == ($past(exec_map_i) | cds_pkg::CODE_MAP_BIT)) else $error("code map not paired");
  a_base_added: assert property ($rose(mem_req_o) && $past(split_en_o && !iss_cross) && // [RULE4]
    $past(iss_addr) >= cds_pkg::BASE_LO && $past(iss_addr) <= cds_pkg::BASE_HI
    |-> mem_addr_o == 15'($past(iss_addr) + $past(base_q_i))) else $error("base not added");
  a_acc_kept: assert property ($rose(mem_req_o) && $past(!iss_code && !iss_cross) && // [RULE5]
    $past(iss_addr) <= cds_pkg::ACC_B_ADDR |-> mem_acc_o && mem_addr_o == $past(iss_addr))
    else $error("accumulator location misrouted");
  a_cross_plain: assert property ($rose(mem_req_o) && $past(iss_cross) // [RULE6]
    |-> mem_addr_o == $past(iss_addr) && mem_map_o == $past(cross_map_i)) else $error("cross access split");
  a_base_page_data: assert property ($rose(mem_req_o) && $past(iss_proc) && // [RULE9]
    $past(acc_kind_i) == cds_pkg::K_MEMREF_BASE |-> !mem_code_o) else $error("base page went to code");
  a_cp_levels: assert property ($rose(mem_req_o) && $past(iss_proc) && // [RULE10]
    $past(acc_kind_i) == cds_pkg::K_MEMREF_CP |-> mem_code_o == $past(acc_first_i))
    else $error("current page level in wrong space");
  a_overflow_check: assert property (call_done_o // [RULE19]
    |-> call_overflow_o == ($past(nextq_q) >= {1'b0, $past(bounds_i)})) else $error("overflow check wrong");
  a_marker_addr: assert property (mem_req_o && mem_we_o && state_q == cds_pkg::S_MARK // [RULE20]
    |-> mem_addr_o == 15'(newq_q + {12'h000, mark_q})) else $error("marker word misplaced");
  a_move_setup: assert property (move_start_i && !move_busy_o && move_count_i == 16'h0000 // [RULE18]
    |-> ##1 move_busy_o[*8] ##SETUP_GAP move_done_o) else $error("move setup time wrong");
  a_split_hold: assert property (split_on_i |=> split_en_o) else $error("split enable not held"); // [RULE21]

  c_call_done: cover property (call_done_o && !call_overflow_o);
  c_call_overflow: cover property (call_overflow_o);
  c_cross_remap: cover property (remap_valid_o && remap_ack_i);
  c_move_done: cover property (move_done_o);

endmodule : cds_unit
`default_nettype wire

// ---- src/cds_xlate.sv ----
`timescale 1ns/10ps
`default_nettype none
module cds_xlate (
  input wire logic split_en_i,
  input wire logic cross_i,
  input wire logic code_i,
  input wire logic [4:0] exec_map_i,
  input wire logic [4:0] cross_map_i,
  input wire logic [14:0] addr_i,
  input wire logic [14:0] base_i,
  output logic [4:0] map_o,
  output logic [14:0] addr_o,
  output logic acc_o
);

  logic split_eff;
  logic in_window;

  // cross-map traffic always sees the unified view
  assign split_eff = split_en_i & ~cross_i; // [RULE6]
  assign in_window = (addr_i >= cds_pkg::BASE_LO) && (addr_i <= cds_pkg::BASE_HI);

  // map choice: cross map, paired code map, or the execute map itself
  always_comb begin
    if (cross_i) begin
      map_o = cross_map_i; // [RULE6]
    end else if (split_eff && code_i) begin
      map_o = exec_map_i | cds_pkg::CODE_MAP_BIT; // [RULE2]
    end else begin
      map_o = exec_map_i; // [RULE1]
    end
  end

  // low data words outside cross-map traffic stay on the accumulators and never take the base
  assign acc_o = ~cross_i & ~code_i & (addr_i <= cds_pkg::ACC_B_ADDR); // [RULE5]
  // sum wraps at 15 bits; a base outside its legal range gives garbage
  assign addr_o = (split_eff && in_window) ? 15'(addr_i + base_i) : addr_i; // [RULE4]

endmodule : cds_xlate
`default_nettype wire
